// ---- logic/agc_pkg.sv ----
// Behaviour
// (R1) Every automatic gain change moves the gain by exactly one half-dB step.
// (R2) Leaving shutdown or disabling automatic control loads the starting gain.
// (R3) With automatic control inactive the starting gain is applied unchanged.
// (R4) Successive gain decreases are at least the attack interval apart.
// (R5) Successive gain increases are at least the release interval apart.
// (R6) First increase after a decrease waits the hold interval instead of release; the code does so only when hold exceeds release.
// (R7) Above the limit with no attack pending, gain drops at once; timers restart.
// (R8) While the attack interval runs, gain stays even if above the limit.
// (R9) Attack expired and still above limit: one step down, timers restart.
// (R10) Release elapsed and still below target: one step up, timers restart.
// (R11) A near-constant input amplitude leaves the gain unchanged.
// (R12) Input level below the noise-gate threshold freezes the gain.
// (R13) Gain decisions come from the detected input envelope against the settings.
// (R14) Host keeps the starting gain within -28 to +30 dB with compression on.
// (R15) Host keeps the starting gain within 0 to 30 dB with compression off.
// (R16) The starting gain setting spans -28 to +30 dB in 1 dB steps.
// (R17) Gain is reduced whenever the output would exceed the limiter level; the code reduces only after attack expiry, ungated, above the floor.
// (R18) Maximum gain is the gain at the low end of the compression region.
// (R19) Automatic increases never drive the gain above the maximum-gain setting.
// (R20) With hold disabled the first increase uses the release interval.
// (R21) Hold applies only after a decrease; later increases use release.
// (R22) Interval counters run on the internal clock and restart on every change.
// (R23) Gain saturates at the lowest and highest codes, never wraps.
package agc_pkg;

    localparam int GAIN_W = 8;
    localparam int LVL_W  = 10;
    localparam int TIME_W = 16;
    localparam int DATA_W = 32;

    localparam logic [3:0] ADDR_CTRL    = 4'h0;
    localparam logic [3:0] ADDR_FIXED   = 4'h1;
    localparam logic [3:0] ADDR_LIMIT   = 4'h2;
    localparam logic [3:0] ADDR_TARGET  = 4'h3;
    localparam logic [3:0] ADDR_MAXGAIN = 4'h4;
    localparam logic [3:0] ADDR_NOISE   = 4'h5;
    localparam logic [3:0] ADDR_ATTACK  = 4'h6;
    localparam logic [3:0] ADDR_RELEASE = 4'h7;
    localparam logic [3:0] ADDR_HOLD    = 4'h8;
    localparam logic [3:0] ADDR_STATUS  = 4'h9;

    localparam int CTRL_AGC_EN   = 0;
    localparam int CTRL_HOLD_EN  = 1;
    localparam int CTRL_COMP_EN  = 2;
    localparam int CTRL_SHUTDOWN = 3;
    localparam int STAT_GATED    = 8;
    localparam int STAT_LASTDEC  = 9;
    localparam int STAT_ENV_LSB  = 16;

    localparam logic [3:0]        CTRL_RST    = 4'h3;
    localparam logic [5:0]        FIXED_RST   = 6'h06;
    localparam logic [5:0]        MAXGAIN_RST = 6'h1E;
    localparam logic [LVL_W-1:0]  LIMIT_RST   = 10'h3F4;
    localparam logic [LVL_W-1:0]  TARGET_RST  = 10'h3E8;
    localparam logic [LVL_W-1:0]  NOISE_RST   = 10'h380;
    localparam logic [TIME_W-1:0] ATTACK_RST  = 16'h0040;
    localparam logic [TIME_W-1:0] RELEASE_RST = 16'h1000;
    localparam logic [TIME_W-1:0] HOLD_RST    = 16'h2000;

    // Gain codes in half-dB units
    localparam logic signed [GAIN_W-1:0] GAIN_MIN  = 8'hC8;
    localparam logic signed [GAIN_W-1:0] GAIN_MAX  = 8'h3C;
    localparam logic signed [GAIN_W-1:0] GAIN_ZERO = 8'h00;
    localparam logic signed [GAIN_W-1:0] GAIN_STEP = 8'h01;
    // Dead band below the target, half-dB units
    localparam logic signed [LVL_W-1:0]  LVL_HYST  = 10'h002;
    localparam logic signed [LVL_W-1:0]  ENV_FLOOR = 10'h340;
    localparam int                       DB6_HALF  = 12;

    typedef enum logic {BUS_IDLE, BUS_ACK} busState_t;

endpackage

// ---- logic/envelope_detector.sv ----
`timescale 1ns/1ps
module envelope_detector
    import agc_pkg::*;
#(
    parameter int SAMPLE_W    = 16,
    parameter int DECAY_SHIFT = 10
) (
    // Clock and reset
    input  wire logic                       mclk,
    input  wire logic                       reset_n,
    // Audio samples
    input  wire logic signed [SAMPLE_W-1:0] sample,
    input  wire logic                       sampleValid,
    // Envelope level, half-dB below full scale
    output logic signed [LVL_W-1:0]         envLevel
);
    logic [SAMPLE_W-2:0]     peak_q;
    logic [SAMPLE_W-2:0]     peak_d;
    logic signed [LVL_W-1:0] level_q;
    logic signed [LVL_W-1:0] level_d;
    logic [SAMPLE_W-2:0]     mag;
    logic [SAMPLE_W-2:0]     decay;
    int                      msb;

    always_comb begin
        mag = sample[SAMPLE_W-1] ? ~sample[SAMPLE_W-2:0] : sample[SAMPLE_W-2:0];
        decay = (peak_q >> DECAY_SHIFT) | {{(SAMPLE_W-2){1'b0}}, (peak_q != '0)};
        if (sampleValid && mag > peak_q) begin
            peak_d = mag;
        end else begin
            peak_d = peak_q - decay;
        end
        // Leading one gives 6 dB per bit
        msb = -1;
        for (int i = 0; i < SAMPLE_W - 1; i++) begin
            if (peak_q[i]) begin
                msb = i;
            end
        end
        if (msb < 0) begin
            level_d = ENV_FLOOR;
        end else begin
            level_d = LVL_W'(DB6_HALF * (msb - (SAMPLE_W - 2)));
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            peak_q  <= '0;
            level_q <= ENV_FLOOR;
        end else begin
            peak_q  <= peak_d;
            level_q <= level_d;
        end
    end

    assign envLevel = level_q;

endmodule

// ---- logic/interval_timer.sv ----
`timescale 1ns/1ps
module interval_timer #(
    parameter int TIME_W = 16,
    parameter int N      = 3
) (
    // Clock and reset
    input  wire logic                mclk,
    input  wire logic                reset_n,
    // Control
    input  wire logic                restart,
    input  wire logic [N*TIME_W-1:0] limits,
    // Status
    output logic [N-1:0]             done,
    output logic [TIME_W-1:0]        elapsed
);
    logic [TIME_W-1:0] elapsed_q;
    logic [TIME_W-1:0] elapsed_d;
    logic [N-1:0]      done_q;
    logic [N-1:0]      done_d;

    // Saturating count of cycles since the last gain change
    always_comb begin
        if (restart) begin
            elapsed_d = '0; // [R22]
        end else if (elapsed_q != '1) begin
            elapsed_d = elapsed_q + TIME_W'(1);
        end else begin
            elapsed_d = elapsed_q;
        end
    end

    generate
        for (genvar g = 0; g < N; g++) begin : gCmp
            assign done_d[g] = elapsed_d >= limits[g*TIME_W +: TIME_W];
        end
    endgenerate

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            elapsed_q <= '0;
            done_q    <= '0;
        end else begin
            elapsed_q <= elapsed_d;
            done_q    <= done_d;
        end
    end

    assign done    = done_q;
    assign elapsed = elapsed_q;

endmodule

// ---- logic/agc_gain_controller.sv ----
`timescale 1ns/1ps
module agc_gain_controller
    import agc_pkg::*;
#(
    parameter int SAMPLE_W    = 16,
    parameter int DECAY_SHIFT = 10
) (
    // Clock and reset
    input  wire logic                       mclk,
    input  wire logic                       reset_n,
    // Avalon-MM slave, word addressed
    input  wire logic [3:0]                 address,
    input  wire logic                       read,
    input  wire logic                       write,
    input  wire logic [DATA_W-1:0]          writedata,
    output logic [DATA_W-1:0]               readdata,
    output logic                            waitrequest,
    // Audio input
    input  wire logic signed [SAMPLE_W-1:0] sample,
    input  wire logic                       sampleValid,
    // Gain stage control, half-dB units
    output logic signed [GAIN_W-1:0]        gainCode
);
    // Bus slave state
    busState_t           busState_q;
    busState_t           busState_d;
    logic                waitReq_q;
    logic                waitReq_d;
    logic [DATA_W-1:0]   readdata_q;
    logic [DATA_W-1:0]   readdata_d;
    logic [DATA_W-1:0]   rdMux;
    logic                regWr;

    // Configuration registers
    logic [3:0]          ctrl_q;
    logic [3:0]          ctrl_d;
    logic [5:0]          fixed_q;
    logic [5:0]          fixed_d;
    logic [5:0]          maxGain_q;
    logic [5:0]          maxGain_d;
    logic [LVL_W-1:0]    limit_q;
    logic [LVL_W-1:0]    limit_d;
    logic [LVL_W-1:0]    target_q;
    logic [LVL_W-1:0]    target_d;
    logic [LVL_W-1:0]    noise_q;
    logic [LVL_W-1:0]    noise_d;
    logic [TIME_W-1:0]   attack_q;
    logic [TIME_W-1:0]   attack_d;
    logic [TIME_W-1:0]   release_q;
    logic [TIME_W-1:0]   release_d;
    logic [TIME_W-1:0]   hold_q;
    logic [TIME_W-1:0]   hold_d;

    // Gain loop state
    logic signed [GAIN_W-1:0] gainCode_q;
    logic signed [GAIN_W-1:0] gainCode_d;
    logic                     lastDec_q;
    logic                     lastDec_d;

    // Gain loop helpers
    logic signed [LVL_W-1:0]  envLevel;
    logic signed [LVL_W-1:0]  outLevel;
    logic signed [GAIN_W-1:0] fixedHalf;
    logic signed [GAIN_W-1:0] maxHalf;
    logic signed [GAIN_W-1:0] ceiling;
    logic signed [GAIN_W-1:0] floorGain;
    logic [2:0]               timerDone;
    logic [TIME_W-1:0]        elapsed;
    logic                     attackDone;
    logic                     releaseDone;
    logic                     holdDone;
    logic                     agcRun;
    logic                     agcOff;
    logic                     holdEn;
    logic                     gated;
    logic                     tooLoud;
    logic                     tooQuiet;
    logic                     riseReady;
    logic                     decNow;
    logic                     incNow;

    envelope_detector #(
        .SAMPLE_W    (SAMPLE_W),
        .DECAY_SHIFT (DECAY_SHIFT)
    ) uEnv (
        .mclk        (mclk),
        .reset_n     (reset_n),
        .sample      (sample),
        .sampleValid (sampleValid),
        .envLevel    (envLevel)
    );

    interval_timer #(
        .TIME_W  (TIME_W),
        .N       (3)
    ) uTimer (
        .mclk    (mclk),
        .reset_n (reset_n),
        .restart (decNow || incNow),
        .limits  ({hold_q, release_q, attack_q}),
        .done    (timerDone),
        .elapsed (elapsed)
    );

    // Bus handshake: one wait cycle, then completion
    always_comb begin
        busState_d = busState_q;
        readdata_d = readdata_q;
        unique case (busState_q)
            BUS_IDLE: begin
                if (read || write) begin
                    busState_d = BUS_ACK;
                    readdata_d = read ? rdMux : '0;
                end
            end
            BUS_ACK: begin
                busState_d = BUS_IDLE;
            end
        endcase
        waitReq_d = (busState_d != BUS_ACK);
    end

    assign regWr = (busState_q == BUS_ACK) && write;

    always_comb begin
        rdMux = '0;
        unique case (address)
            ADDR_CTRL:    rdMux[3:0] = ctrl_q;
            ADDR_FIXED:   rdMux[5:0] = fixed_q;
            ADDR_LIMIT:   rdMux[LVL_W-1:0] = limit_q;
            ADDR_TARGET:  rdMux[LVL_W-1:0] = target_q;
            ADDR_MAXGAIN: rdMux[5:0] = maxGain_q;
            ADDR_NOISE:   rdMux[LVL_W-1:0] = noise_q;
            ADDR_ATTACK:  rdMux[TIME_W-1:0] = attack_q;
            ADDR_RELEASE: rdMux[TIME_W-1:0] = release_q;
            ADDR_HOLD:    rdMux[TIME_W-1:0] = hold_q;
            ADDR_STATUS: begin
                rdMux[GAIN_W-1:0] = gainCode_q;
                rdMux[STAT_GATED] = gated;
                rdMux[STAT_LASTDEC] = lastDec_q;
                rdMux[STAT_ENV_LSB +: LVL_W] = envLevel;
            end
            default: rdMux = '0;
        endcase
    end

    always_comb begin
        ctrl_d    = ctrl_q;
        fixed_d   = fixed_q;
        maxGain_d = maxGain_q;
        limit_d   = limit_q;
        target_d  = target_q;
        noise_d   = noise_q;
        attack_d  = attack_q;
        release_d = release_q;
        hold_d    = hold_q;
        if (regWr) begin
            unique case (address)
                ADDR_CTRL:    ctrl_d = writedata[3:0];
                ADDR_FIXED:   fixed_d = writedata[5:0]; // [R16]
                ADDR_LIMIT:   limit_d = writedata[LVL_W-1:0];
                ADDR_TARGET:  target_d = writedata[LVL_W-1:0];
                ADDR_MAXGAIN: maxGain_d = writedata[5:0];
                ADDR_NOISE:   noise_d = writedata[LVL_W-1:0];
                ADDR_ATTACK:  attack_d = writedata[TIME_W-1:0];
                ADDR_RELEASE: release_d = writedata[TIME_W-1:0];
                ADDR_HOLD:    hold_d = writedata[TIME_W-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            busState_q <= BUS_IDLE;
            waitReq_q  <= 1'b1;
            readdata_q <= '0;
            ctrl_q     <= CTRL_RST;
            fixed_q    <= FIXED_RST;
            maxGain_q  <= MAXGAIN_RST;
            limit_q    <= LIMIT_RST;
            target_q   <= TARGET_RST;
            noise_q    <= NOISE_RST;
            attack_q   <= ATTACK_RST;
            release_q  <= RELEASE_RST;
            hold_q     <= HOLD_RST;
        end else begin
            busState_q <= busState_d;
            waitReq_q  <= waitReq_d;
            readdata_q <= readdata_d;
            ctrl_q     <= ctrl_d;
            fixed_q    <= fixed_d;
            maxGain_q  <= maxGain_d;
            limit_q    <= limit_d;
            target_q   <= target_d;
            noise_q    <= noise_d;
            attack_q   <= attack_d;
            release_q  <= release_d;
            hold_q     <= hold_d;
        end
    end

    // Gain loop decision
    always_comb begin
        agcRun = ctrl_q[CTRL_AGC_EN] && !ctrl_q[CTRL_SHUTDOWN];
        agcOff = !agcRun;
        holdEn = ctrl_q[CTRL_HOLD_EN] && (hold_q > release_q);
        attackDone  = timerDone[0];
        releaseDone = timerDone[1];
        holdDone    = timerDone[2];
        fixedHalf = {fixed_q[5], fixed_q, 1'b0};
        maxHalf   = {maxGain_q[5], maxGain_q, 1'b0};
        ceiling   = (maxHalf > GAIN_MAX) ? GAIN_MAX : maxHalf; // [R18] [R19]
        floorGain = ctrl_q[CTRL_COMP_EN] ? GAIN_MIN : GAIN_ZERO; // [R23]
        outLevel = envLevel + {{(LVL_W-GAIN_W){gainCode_q[GAIN_W-1]}}, gainCode_q}; // [R13]
        gated    = envLevel < $signed(noise_q); // [R12]
        tooLoud  = outLevel > $signed(limit_q); // [R17]
        tooQuiet = outLevel < ($signed(target_q) - LVL_HYST); // [R11]
        riseReady = (lastDec_q && holdEn) ? holdDone : releaseDone; // [R6] [R20] [R21]
        decNow = agcRun && !gated && tooLoud && attackDone && (gainCode_q > floorGain); // [R7] [R8] [R9]
        incNow = agcRun && !gated && !tooLoud && tooQuiet && riseReady
                 && (gainCode_q < ceiling); // [R10] [R19]
        gainCode_d = gainCode_q;
        lastDec_d  = lastDec_q;
        if (agcOff) begin
            gainCode_d = fixedHalf; // [R2] [R3]
            lastDec_d  = 1'b0;
        end else if (decNow) begin
            gainCode_d = gainCode_q - GAIN_STEP; // [R1] [R4]
            lastDec_d  = 1'b1;
        end else if (incNow) begin
            gainCode_d = gainCode_q + GAIN_STEP; // [R1] [R5]
            lastDec_d  = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            gainCode_q <= {FIXED_RST[5], FIXED_RST, 1'b0};
            lastDec_q  <= 1'b0;
        end else begin
            gainCode_q <= gainCode_d;
            lastDec_q  <= lastDec_d;
        end
    end

    assign readdata    = readdata_q;
    assign waitrequest = waitReq_q;
    assign gainCode    = gainCode_q;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    chk_half_step_down: assert property ( // [R1]
        decNow |=> (gainCode_q + GAIN_STEP) == $past(gainCode_q))
        else $error("gain decrease was not one half-dB step");

    chk_fixed_load: assert property ( // [R2]
        agcOff |=> gainCode_q == $past(fixedHalf))
        else $error("starting gain not loaded while control inactive");

    chk_fixed_steady: assert property ( // [R3]
        $past(agcOff, 2) && $past(agcOff) && $past(fixed_q, 2) == $past(fixed_q)
        |-> $stable(gainCode_q))
        else $error("gain moved while control inactive");

    chk_attack_gap: assert property ( // [R4]
        agcRun && (gainCode_q < $past(gainCode_q)) && $past(agcRun)
        |-> $past(elapsed) >= $past(attack_q))
        else $error("decreases closer than attack interval");

    chk_release_gap: assert property ( // [R5]
        incNow |-> elapsed >= release_q)
        else $error("increases closer than release interval");

    chk_hold_first: assert property ( // [R6]
        incNow && lastDec_q && ctrl_q[CTRL_HOLD_EN] && hold_q > release_q
        |-> elapsed >= hold_q)
        else $error("first increase came before hold interval");

    chk_fast_attack: assert property ( // [R7]
        agcRun && !gated && tooLoud && attackDone && gainCode_q > floorGain
        |=> gainCode_q < $past(gainCode_q) ##1 elapsed == TIME_W'(1))
        else $error("loud input did not drop gain at once");

    chk_attack_wait: assert property ( // [R8]
        agcRun && !attackDone ##1 agcRun |-> gainCode_q >= $past(gainCode_q))
        else $error("gain dropped inside attack interval");

    chk_timer_restart: assert property ( // [R22]
        decNow || incNow |=> elapsed == '0 && timerDone == 3'b000
        || attack_q == '0 || release_q == '0 || hold_q == '0)
        else $error("interval counter not restarted on gain change");

    chk_gate_freeze: assert property ( // [R12]
        agcRun && gated ##1 agcRun |-> $stable(gainCode_q))
        else $error("gain moved below noise gate");

    chk_gain_ceiling: assert property ( // [R19]
        incNow |=> gainCode_q <= $past(ceiling))
        else $error("increase went above maximum gain");

    chk_gain_range: assert property ( // [R23]
        agcRun |-> gainCode_q >= GAIN_MIN && gainCode_q <= GAIN_MAX)
        else $error("gain code out of range");

    cov_decrease: cover property (decNow ##1 !decNow [*4] ##1 decNow);
    cov_hold_rise: cover property (incNow && lastDec_q && holdEn);
    cov_gate: cover property (agcRun && gated && tooLoud);
    cov_bus_write: cover property (regWr && address == ADDR_CTRL);

endmodule

// ---- verif/audio_source_model.sv ----
`timescale 1ns/1ps
module audio_source_model (
    // Clock and reset
    input  wire logic               mclk,
    input  wire logic               reset_n,
    // Peak level asked for by the bench
    input  wire logic signed [15:0] amplitude,
    // Audio samples
    output logic signed [15:0]      sample,
    output logic                    sampleValid
);
    logic phase_q;

    // Square wave of the requested peak, a sample every cycle
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            phase_q     <= 1'b0;
            sample      <= 16'h0000;
            sampleValid <= 1'b0;
        end else begin
            phase_q     <= ~phase_q;
            sample      <= phase_q ? -amplitude : amplitude;
            sampleValid <= 1'b1;
        end
    end
endmodule

// ---- verif/agc_gain_controller_tb_top.sv ----
`timescale 1ns/1ps
module agc_gain_controller_tb_top;
    import agc_pkg::*;

    logic                     mclk;
    logic                     reset_n;
    logic [3:0]               address;
    logic                     read;
    logic                     write;
    logic [DATA_W-1:0]        writedata;
    logic [DATA_W-1:0]        readdata;
    logic                     waitrequest;
    logic signed [15:0]       amplitude;
    logic signed [15:0]       sample;
    logic                     sampleValid;
    logic signed [GAIN_W-1:0] gainCode;
    logic signed [GAIN_W-1:0] prevGain;
    logic [DATA_W-1:0]        rd;
    logic                     monOn;
    logic                     first;
    logic                     lastDec;
    int                       n_errors;
    int                       check_count;
    int                       cyc;
    int                       lastCyc;
    int                       need;
    int                       attackCfg;
    int                       releaseCfg;
    int                       holdCfg;

    agc_gain_controller #(.SAMPLE_W(16), .DECAY_SHIFT(2)) u_agc_gain_controller (
        .mclk(mclk), .reset_n(reset_n), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .sample(sample), .sampleValid(sampleValid), .gainCode(gainCode));

    audio_source_model u_audio_source_model (
        .mclk(mclk), .reset_n(reset_n), .amplitude(amplitude),
        .sample(sample), .sampleValid(sampleValid));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test();
        if (n_errors == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // Avalon transfer, held until waitrequest is seen low
    task automatic bus_op(input logic wr, input logic [3:0] addr, input logic [31:0] data);
        int k;
        k = 0;
        address   <= addr;
        writedata <= data;
        write     <= wr;
        read      <= ~wr;
        @(posedge mclk);
        while (waitrequest !== 1'b0 && k < 20) begin
            @(posedge mclk);
            k++;
        end
        if (k == 20) n_errors++;
        rd = readdata;
        read  <= 1'b0;
        write <= 1'b0;
        @(posedge mclk);
    endtask

    // Step size and spacing of every automatic change
    always @(posedge mclk) begin
        cyc++;
        if (monOn && gainCode !== prevGain) begin
            check("gain step", gainCode - prevGain == 1 || prevGain - gainCode == 1, 1);
            need = (gainCode < prevGain) ? attackCfg
                 : (lastDec && holdCfg > releaseCfg) ? holdCfg : releaseCfg;
            if (!first) check("change spacing", cyc - lastCyc >= need, 1);
            lastDec = gainCode < prevGain;
            first   = 1'b0;
            lastCyc = cyc;
        end
        prevGain = gainCode;
    end

    task automatic test_reset();
        check("gain after reset", gainCode, 12);
        bus_op(1'b1, 4'hA, 32'h0000_FFFF);
        bus_op(1'b0, 4'hA, 32'h0000_0000);
        check("unmapped read", rd, 32'h0000_0000);
        bus_op(1'b0, ADDR_CTRL, 32'h0000_0000);
        check("ctrl reset", rd, 32'h0000_0003);
        bus_op(1'b0, ADDR_ATTACK, 32'h0000_0000);
        check("attack reset", rd, 32'h0000_0040);
        bus_op(1'b0, ADDR_STATUS, 32'h0000_0000);
        check("silent gated", rd[STAT_GATED], 1);
    endtask

    // Loud input, control off or shut down: starting gain must hold
    task automatic test_fixed();
        logic [3:0] ctl[3] = '{4'h4, 4'h4, 4'h9};
        logic [5:0] fx[3]  = '{6'h24, 6'h1E, 6'h00};
        int         eg[3]  = '{-56, 60, 0};
        amplitude <= 16'h4000;
        for (int i = 0; i < 3; i++) begin
            bus_op(1'b1, ADDR_CTRL, {28'h000_0000, ctl[i]});
            bus_op(1'b1, ADDR_FIXED, {26'h000_0000, fx[i]});
            cycles(40);
            check("fixed gain", gainCode, eg[i]);
        end
    endtask

    // Loud input drives gain to the floor, then a quieter one raises it
    task automatic test_attack_hold();
        int k;
        k = 0;
        bus_op(1'b1, ADDR_FIXED, 32'h0000_000A);
        bus_op(1'b1, ADDR_ATTACK, 32'h0000_0004);
        bus_op(1'b1, ADDR_RELEASE, 32'h0000_0014);
        bus_op(1'b1, ADDR_HOLD, 32'h0000_0028);
        bus_op(1'b1, ADDR_MAXGAIN, 32'h0000_0008);
        attackCfg  = 4;
        releaseCfg = 20;
        holdCfg    = 40;
        check("start gain", gainCode, 20);
        first = 1'b1;
        monOn = 1'b1;
        bus_op(1'b1, ADDR_CTRL, 32'h0000_0003);
        while (gainCode !== 8'h00 && k < 400) begin
            @(posedge mclk);
            k++;
        end
        amplitude <= 16'h0400;
        check("attack floor", gainCode, 0);
        bus_op(1'b0, ADDR_STATUS, 32'h0000_0000);
        check("last decrease", rd[STAT_LASTDEC], 1);
        cycles(600);
        check("gain ceiling", gainCode, 16);
    endtask

    // Silence under the gate threshold freezes the gain
    task automatic test_gate();
        logic signed [GAIN_W-1:0] g;
        bus_op(1'b1, ADDR_MAXGAIN, 32'h0000_001E);
        amplitude <= 16'h0000;
        cycles(100);
        g = gainCode;
        cycles(400);
        check("gated gain", gainCode, g);
        bus_op(1'b0, ADDR_STATUS, 32'h0000_0000);
        check("gated flag", rd[STAT_GATED], 1);
    endtask

    // Hold off, compression on: floor at -28 dB, first rise after release only
    task automatic test_no_hold();
        int k;
        int n;
        k = 0;
        n = 0;
        bus_op(1'b1, ADDR_LIMIT, 32'h0000_039C);
        bus_op(1'b1, ADDR_CTRL, 32'h0000_0005);
        holdCfg = 0;
        amplitude <= 16'h4000;
        while (gainCode !== 8'hC8 && k < 800) begin
            @(posedge mclk);
            k++;
        end
        amplitude <= 16'h0400;
        check("compressed floor", gainCode, -56);
        while (gainCode === 8'hC8 && n < 100) begin
            @(posedge mclk);
            n++;
        end
        check("release after fall", n, releaseCfg + 1);
    endtask

    initial begin
        #200_000;
        n_errors++;
        stop_test();
    end

    initial begin
        reset_n     = 1'b0;
        address     = 4'h0;
        read        = 1'b0;
        write       = 1'b0;
        writedata   = 32'h0000_0000;
        amplitude   = 16'h0000;
        monOn       = 1'b0;
        first       = 1'b1;
        lastDec     = 1'b0;
        n_errors    = 0;
        check_count = 0;
        cyc         = 0;
        lastCyc     = 0;
        attackCfg   = 0;
        releaseCfg  = 0;
        holdCfg     = 0;
        repeat (6) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        test_reset();
        test_fixed();
        test_attack_hold();
        test_gate();
        test_no_hold();
        stop_test();
    end
endmodule
